/* File: rtl/wdtc_pkg.sv */
// Purpose: shared constants and types of the watchdog and countdown timer
// Assumes: 50 MHz system clock, byte-wide register port
// Notes:   prescale and reset counts derived from times and rates below
package wdtc_pkg;

    // ****************************************
    // clock and tick rates
    // ****************************************
    localparam int CLK_HZ      = 50_000_000;
    localparam int SRC_HZ      = 4096;
    localparam int CLK_PER_SRC = CLK_HZ / SRC_HZ;
    localparam int DIV_64HZ    = 64;
    localparam int DIV_1HZ     = 64;
    localparam int DIV_MIN     = 60;
    localparam int PRE_W       = 16;
    localparam int DIV_W       = 6;

    // ****************************************
    // output pulse widths
    // ****************************************
    localparam int RST_SHORT_NS  = 244_000;
    localparam int RST_LONG_NS   = 15_625_000;
    localparam int RST_SHORT_CYC = int'((longint'(RST_SHORT_NS) * CLK_HZ) / 1_000_000_000);
    localparam int RST_LONG_CYC  = int'((longint'(RST_LONG_NS) * CLK_HZ) / 1_000_000_000);
    localparam int RST_CNT_W     = 20;
    localparam int IRQ_PULSE_CYC = 16;
    localparam int IRQ_CNT_W     = 5;

    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [7:0] ADDR_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_CTRL  = 8'h10;
    localparam logic [7:0] ADDR_VAL   = 8'h11;
    localparam int MSF_BIT   = 7;
    localparam int WATCHDOG_EXPIRED_FLAG_BIT  = 6;
    localparam int COUNTDOWN_EXPIRED_FLAG_BIT  = 3;
    localparam int MODE_LSB  = 6;
    localparam int PULSE_BIT = 5;
    localparam logic       PULSE_RST   = 1'b0;
    localparam logic [1:0] CLK_SEL_RST = 2'h3;
    localparam logic [7:0] VAL_RST     = 8'h00;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_CD     = 2'b01,
        MODE_WD_IRQ = 2'b10,
        MODE_WD_RST = 2'b11
    } wdtc_mode_e;

    typedef enum logic [1:0] {
        SRC_4K  = 2'b00,
        SRC_64  = 2'b01,
        SRC_1   = 2'b10,
        SRC_MIN = 2'b11
    } wdtc_src_e;

endpackage

/* File: rtl/wdtc_tick_gen.sv */
// Purpose: one-cycle source ticks at 4.096 kHz, 64 Hz, 1 Hz and 1/60 Hz
// Assumes: system clock divided down in place of the crystal clock
// Notes:   tick_o index follows the clock selector code
`timescale 1ns/1ps
`default_nettype none

module wdtc_tick_gen
    import wdtc_pkg::*;
#(
    parameter int CLK_PER_4K = CLK_PER_SRC
)(
    input  wire logic       clock,
    input  wire logic       rst_n,
    output logic [3:0]      tick_o
);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [DIV_W-1:0] c64;
        logic [DIV_W-1:0] c1;
        logic [DIV_W-1:0] cmin;
        logic [3:0]       tick;
    } wdtc_tick_s;

    wdtc_tick_s st_r;
    wdtc_tick_s st_nxt;

    // ****************************************
    // cascaded dividers
    // ****************************************
    // cascade keeps every tick aligned with the fastest one
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 4'h0;
        if (st_r.pre == PRE_W'(CLK_PER_4K - 1))
        begin
            st_nxt.pre     = '0;
            st_nxt.tick[0] = 1'b1;
            if (st_r.c64 == DIV_W'(DIV_64HZ - 1))
            begin
                st_nxt.c64     = '0;
                st_nxt.tick[1] = 1'b1;
                if (st_r.c1 == DIV_W'(DIV_1HZ - 1))
                begin
                    st_nxt.c1      = '0;
                    st_nxt.tick[2] = 1'b1;
                    if (st_r.cmin == DIV_W'(DIV_MIN - 1))
                    begin
                        st_nxt.cmin    = '0;
                        st_nxt.tick[3] = 1'b1;
                    end
                    else
                    begin
                        st_nxt.cmin = st_r.cmin + 1'b1;
                    end
                end
                else
                begin
                    st_nxt.c1 = st_r.c1 + 1'b1;
                end
            end
            else
            begin
                st_nxt.c64 = st_r.c64 + 1'b1;
            end
        end
        else
        begin
            st_nxt.pre = st_r.pre + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;

endmodule // wdtc_tick_gen

`default_nettype wire

/* File: rtl/wdtc_timer.sv */
// Purpose: watchdog and countdown timer with flag register and pin drive
// Assumes: register port strobes are single-cycle and synchronous
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module wdtc_timer
    import wdtc_pkg::*;
#(
    parameter int CLK_PER_4K = CLK_PER_SRC,
    parameter int RST_SHORT  = RST_SHORT_CYC,
    parameter int RST_LONG   = RST_LONG_CYC
)(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       sec_min_tick,
    output logic            int_o_n,
    output logic            rst_o_n
);

    typedef struct packed {
        wdtc_mode_e           mode;
        logic                 pulse_sel;
        logic [1:0]           clk_sel;
        logic [7:0]           nval;
        logic [7:0]           cnt;
        logic                 run;
        logic                 tick_interrupt_flag;
        logic                 countdown_expired_flag;
        logic                 watchdog_expired_flag;
        logic [IRQ_CNT_W-1:0] irq_cnt;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic [7:0]           rdata;
        logic                 int_n;
        logic                 rst_out_n;
    } wdtc_state_s;

    localparam wdtc_state_s ST_RST = '{
        mode: MODE_OFF, pulse_sel: PULSE_RST, clk_sel: CLK_SEL_RST,
        nval: VAL_RST, cnt: VAL_RST, run: 1'b0, tick_interrupt_flag: 1'b0, countdown_expired_flag: 1'b0,
        watchdog_expired_flag: 1'b0, irq_cnt: '0, rst_cnt: '0, rdata: 8'h00,
        int_n: 1'b1, rst_out_n: 1'b1};

    wdtc_state_s st_r;
    wdtc_state_s st_nxt;
    logic [3:0]  tick_vec;
    logic        tick;
    logic        wd_set;
    logic        cd_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        return a == t;
    endfunction

    function automatic logic is_wd(input wdtc_mode_e m);
        return (m == MODE_WD_IRQ) || (m == MODE_WD_RST);
    endfunction

    // ****************************************
    // source ticks
    // ****************************************
    // divided tick enables
    wdtc_tick_gen #(
        .CLK_PER_4K (CLK_PER_4K)
    ) u_tick (
        .clock  (clock),
        .rst_n  (rst_n),
        .tick_o (tick_vec)
    );

    always_comb
    begin
        case (wdtc_src_e'(st_r.clk_sel))
            SRC_4K:  tick = tick_vec[0];
            SRC_64:  tick = tick_vec[1];
            SRC_1:   tick = tick_vec[2];
            SRC_MIN: tick = tick_vec[3];
            default: tick = 1'b0;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        wd_set = 1'b0;
        cd_set = 1'b0;
        if (reg_wr_en && hit(reg_addr, ADDR_CTRL))
        begin
            st_nxt.mode      = wdtc_mode_e'(reg_wdata[MODE_LSB +: 2]);
            st_nxt.pulse_sel = reg_wdata[PULSE_BIT];
            st_nxt.clk_sel   = reg_wdata[1:0];
        end
        // flag write ands only clearable flags
        if (reg_wr_en && hit(reg_addr, ADDR_FLAGS))
        begin
            st_nxt.tick_interrupt_flag  = st_r.tick_interrupt_flag & reg_wdata[MSF_BIT];
            st_nxt.countdown_expired_flag = st_r.countdown_expired_flag & reg_wdata[COUNTDOWN_EXPIRED_FLAG_BIT];
        end
        if (reg_rd_en && hit(reg_addr, ADDR_FLAGS))
        begin
            st_nxt.watchdog_expired_flag = 1'b0;
        end
        if (reg_wr_en && hit(reg_addr, ADDR_VAL))
        begin
            st_nxt.nval = reg_wdata;
            st_nxt.cnt  = reg_wdata;
            st_nxt.run  = (reg_wdata != 8'h00);
            st_nxt.watchdog_expired_flag = 1'b0;
        end
        // counting only in an active mode
        else if ((st_r.mode != MODE_OFF) && st_r.run && tick)
        begin
            if (st_r.cnt == 8'h01)
            begin
                if (is_wd(st_r.mode))
                begin
                    wd_set     = 1'b1;
                    st_nxt.run = 1'b0;
                end
                else
                begin
                    cd_set     = 1'b1;
                    st_nxt.cnt = st_r.nval;
                end
            end
            else
            begin
                st_nxt.cnt = st_r.cnt - 8'h01;
            end
        end
        // hardware sets win over software clears
        st_nxt.tick_interrupt_flag  = st_nxt.tick_interrupt_flag | sec_min_tick;
        st_nxt.countdown_expired_flag = st_nxt.countdown_expired_flag | cd_set;
        st_nxt.watchdog_expired_flag = st_nxt.watchdog_expired_flag | wd_set;
        // pulse restarts on every tick or countdown flag event, not on watchdog expiry
        if (sec_min_tick || cd_set)
        begin
            st_nxt.irq_cnt = IRQ_CNT_W'(IRQ_PULSE_CYC);
        end
        else if (st_r.irq_cnt != '0)
        begin
            st_nxt.irq_cnt = st_r.irq_cnt - 1'b1;
        end
        if (wd_set && (st_r.mode == MODE_WD_RST))
        begin
            st_nxt.rst_cnt = (wdtc_src_e'(st_r.clk_sel) == SRC_4K) ?
                             RST_CNT_W'(RST_SHORT) : RST_CNT_W'(RST_LONG);
        end
        else if (st_r.rst_cnt != '0)
        begin
            st_nxt.rst_cnt = st_r.rst_cnt - 1'b1;
        end
        // released pin must not linger once the flag is gone
        if (!st_nxt.watchdog_expired_flag || (st_nxt.mode != MODE_WD_RST))
        begin
            st_nxt.rst_cnt = '0;
        end
        st_nxt.int_n = !((st_nxt.pulse_sel ? (st_nxt.irq_cnt != '0)
                                           : (st_nxt.tick_interrupt_flag | st_nxt.countdown_expired_flag))
                         || (st_nxt.watchdog_expired_flag && (st_nxt.mode == MODE_WD_IRQ)));
        st_nxt.rst_out_n = (st_nxt.rst_cnt == '0);
        if (reg_rd_en)
        begin
            case (reg_addr)
                ADDR_FLAGS: st_nxt.rdata = {st_r.tick_interrupt_flag, st_r.watchdog_expired_flag, 2'b00, st_r.countdown_expired_flag, 3'b000};
                ADDR_CTRL:  st_nxt.rdata = {st_r.mode, st_r.pulse_sel, 3'b000, st_r.clk_sel};
                ADDR_VAL:   st_nxt.rdata = st_r.cnt;
                default:    st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign int_o_n   = st_r.int_n;
    assign rst_o_n   = st_r.rst_out_n;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_ctrl_zero;
        reg_rd_en && hit(reg_addr, ADDR_CTRL) |=> reg_rdata[4:2] == 3'b000;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("unused control bits read nonzero");

    property p_wd_expire;
        !reg_wr_en && is_wd(st_r.mode) && st_r.run && tick && st_r.cnt == 8'h01
        |=> st_r.watchdog_expired_flag && !st_r.run && st_r.cnt == 8'h01;
    endproperty
    a_wd_expire: assert property (p_wd_expire)
        else $error("watchdog expiry not flagged or counter moved");

    property p_step;
        !reg_wr_en && st_r.mode != MODE_OFF && st_r.run && tick && st_r.cnt > 8'h01
        |=> st_r.cnt == $past(st_r.cnt) - 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not step by one");

    property p_no_reload;
        !st_r.run && is_wd(st_r.mode) && !(reg_wr_en && hit(reg_addr, ADDR_VAL))
        |=> $stable(st_r.cnt) && !st_r.run;
    endproperty
    a_no_reload: assert property (p_no_reload)
        else $error("stopped watchdog restarted itself");

    property p_service;
        reg_wr_en && hit(reg_addr, ADDR_VAL)
        |=> !st_r.watchdog_expired_flag && st_r.cnt == $past(reg_wdata)
            && st_r.run == ($past(reg_wdata) != 8'h00) && rst_o_n;
    endproperty
    a_service: assert property (p_service)
        else $error("count write did not clear and restart");

    property p_read_clear;
        reg_rd_en && hit(reg_addr, ADDR_FLAGS) && !wd_set |=> !st_r.watchdog_expired_flag;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("flag read left expiry set");

    property p_ro_flag;
        reg_wr_en && hit(reg_addr, ADDR_FLAGS) && !reg_rd_en && !wd_set
        |=> st_r.watchdog_expired_flag == $past(st_r.watchdog_expired_flag);
    endproperty
    a_ro_flag: assert property (p_ro_flag)
        else $error("write changed expiry flag");

    property p_reload;
        !reg_wr_en && st_r.mode == MODE_CD && st_r.run && tick && st_r.cnt == 8'h01
        |=> st_r.countdown_expired_flag && st_r.cnt == $past(st_r.nval) && !int_o_n;
    endproperty
    a_reload: assert property (p_reload)
        else $error("countdown did not flag and reload");

    property p_wd_irq;
        st_r.watchdog_expired_flag && st_r.mode == MODE_WD_IRQ |-> !int_o_n;
    endproperty
    a_wd_irq: assert property (p_wd_irq)
        else $error("interrupt not asserted on expiry");

    property p_rst_pin;
        !rst_o_n |-> st_r.watchdog_expired_flag && st_r.mode == MODE_WD_RST;
    endproperty
    a_rst_pin: assert property (p_rst_pin)
        else $error("reset pin asserted without expiry");

    property p_level;
        !st_r.pulse_sel && (st_r.tick_interrupt_flag || st_r.countdown_expired_flag) |-> !int_o_n;
    endproperty
    a_level: assert property (p_level)
        else $error("level interrupt not following flags");

    c_wd_expire: cover property (wd_set && st_r.mode == MODE_WD_RST);
    c_reload: cover property (cd_set ##[1:300] cd_set);
    c_read_clear: cover property (st_r.watchdog_expired_flag ##1 reg_rd_en && hit(reg_addr, ADDR_FLAGS));
    c_rst_end: cover property (!rst_o_n ##1 rst_o_n);

endmodule // wdtc_timer

`default_nettype wire

/* File: test/wdtc_host_model.sv */
// Purpose: host model driving the timer register port and tick input
// Assumes: one-cycle strobes launched just after a rising edge
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module wdtc_host_model (
    input  wire logic       clock,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            sec_min_tick
);
    initial
    begin
        reg_wr_en    = 1'b0;
        reg_rd_en    = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        sec_min_tick = 1'b0;
    end

    // ****************************************
    // register cycles
    // ****************************************
    // host services by count write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge clock);
        reg_rd_en <= 1'b0;
    endtask

    task automatic tick();
        @(posedge clock);
        sec_min_tick <= 1'b1;
        @(posedge clock);
        sec_min_tick <= 1'b0;
    endtask
endmodule // wdtc_host_model

`default_nettype wire

/* File: test/tb_wdtc_timer.sv */
// Purpose: self-checking bench of the watchdog and countdown timer
// Assumes: shortened divider and reset widths for run time
// Notes:   reads checked from a queue of expected values
`timescale 1ns/1ps
`default_nettype none

module tb_wdtc_timer
    import wdtc_pkg::*;
;
    localparam int CP4K = 4;
    localparam int RS   = 5;
    localparam int RL   = 9;

    logic       clock;
    logic       rst_n;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       sec_min_tick;
    logic       int_o_n;
    logic       rst_o_n;
    logic       rd_seen;
    logic [7:0] exp_q[$];
    int         fail_count;
    int         comparisons;
    int         cycles;
    int         width;

    initial clock = 1'b0;
    always #10 clock = ~clock;

    wdtc_host_model host (
        .clock        (clock),
        .reg_wr_en    (reg_wr_en),
        .reg_rd_en    (reg_rd_en),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .sec_min_tick (sec_min_tick)
    );

    wdtc_timer #(.CLK_PER_4K(CP4K), .RST_SHORT(RS), .RST_LONG(RL)) uut (
        .clock        (clock),
        .rst_n        (rst_n),
        .reg_wr_en    (reg_wr_en),
        .reg_rd_en    (reg_rd_en),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_rdata    (reg_rdata),
        .sec_min_tick (sec_min_tick),
        .int_o_n      (int_o_n),
        .rst_o_n      (rst_o_n)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // read data is valid one cycle after the strobe
    always @(posedge clock)
    begin
        if (rd_seen === 1'b1)
        begin
            if (exp_q.size() > 0)
                chk("read data", {24'h0, exp_q.pop_front()}, {24'h0, reg_rdata});
            else
                chk("read queue", 0, 1);
        end
        rd_seen <= reg_rd_en;
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 25000)
        begin
            fail_count++;
            finish_test();
        end
    end

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    // pins sampled at the falling edge, where they are settled
    task automatic wait_pin(input bit use_rst, input logic lvl, input int lim);
        int n;
        n = 0;
        @(negedge clock);
        while ((use_rst ? rst_o_n : int_o_n) !== lvl && n < lim)
        begin
            @(negedge clock);
            n++;
        end
        chk("pin level", {31'h0, lvl}, {31'h0, (use_rst ? rst_o_n : int_o_n)});
    endtask

    task automatic low_width(input bit use_rst, input int exp);
        width = 0;
        while ((use_rst ? rst_o_n : int_o_n) === 1'b0 && width < 40)
        begin
            @(negedge clock);
            width++;
        end
        chk("low width", exp, width);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        logic [7:0] d;
        rst_n       = 1'b0;
        rd_seen     = 1'b0;
        fail_count  = 0;
        comparisons = 0;
        cycles      = 0;
        void'($urandom(32'hf805_91e1));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(ADDR_CTRL, 8'h03);
        rd_chk(ADDR_VAL, VAL_RST);
        rd_chk(ADDR_FLAGS, 8'h00);
        host.wr(ADDR_CTRL, 8'hff);
        rd_chk(ADDR_CTRL, 8'he3);
        host.wr(ADDR_CTRL, 8'h00);
        rd_chk(8'h20, 8'h00);
        // counter idles while both timers are off
        repeat (8)
        begin
            d = 8'($urandom);
            host.wr(ADDR_VAL, d);
            repeat (10) @(posedge clock);
            rd_chk(ADDR_VAL, d);
        end
        host.wr(ADDR_CTRL, 8'hc0);
        host.wr(ADDR_VAL, 8'h03);
        repeat (8) @(negedge clock);
        chk("early reset", 1, {31'h0, rst_o_n});
        wait_pin(1, 1'b0, 12);
        low_width(1, RS);
        rd_chk(ADDR_VAL, 8'h01);
        rd_chk(ADDR_FLAGS, 8'h40);
        rd_chk(ADDR_FLAGS, 8'h00);
        host.wr(ADDR_CTRL, 8'h80);
        host.wr(ADDR_VAL, 8'h02);
        wait_pin(0, 1'b0, 16);
        host.wr(ADDR_FLAGS, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h40);
        wait_pin(0, 1'b1, 3);
        host.wr(ADDR_VAL, 8'h02);
        wait_pin(0, 1'b0, 16);
        host.wr(ADDR_VAL, 8'h00);
        wait_pin(0, 1'b1, 2);
        repeat (20) @(posedge clock);
        rd_chk(ADDR_VAL, 8'h00);
        host.wr(ADDR_VAL, 8'h06);
        repeat (5)
        begin
            repeat (12) @(negedge clock);
            chk("serviced int", 1, {31'h0, int_o_n});
            host.wr(ADDR_VAL, 8'h06);
        end
        wait_pin(0, 1'b0, 32);
        host.wr(ADDR_VAL, 8'h00);
        // slower source stretches the reset pulse
        host.wr(ADDR_CTRL, 8'hc1);
        host.wr(ADDR_VAL, 8'h01);
        wait_pin(1, 1'b0, 520);
        low_width(1, RL);
        rd_chk(ADDR_FLAGS, 8'h40);
        // one hertz source, long pulse as well
        host.wr(ADDR_CTRL, 8'hc2);
        host.wr(ADDR_VAL, 8'h01);
        wait_pin(1, 1'b0, 16400);
        low_width(1, RL);
        rd_chk(ADDR_FLAGS, 8'h40);
        host.wr(ADDR_CTRL, 8'h40);
        host.wr(ADDR_VAL, 8'h02);
        wait_pin(0, 1'b0, 16);
        rd_chk(ADDR_FLAGS, 8'h08);
        host.wr(ADDR_FLAGS, 8'hf7);
        wait_pin(0, 1'b1, 3);
        wait_pin(0, 1'b0, 16);
        host.wr(ADDR_VAL, 8'h1e);
        host.wr(ADDR_CTRL, 8'h60);
        host.wr(ADDR_FLAGS, 8'h00);
        wait_pin(0, 1'b1, 20);
        wait_pin(0, 1'b0, 130);
        low_width(0, IRQ_PULSE_CYC);
        host.wr(ADDR_CTRL, 8'h00);
        host.wr(ADDR_FLAGS, 8'h00);
        wait_pin(0, 1'b1, 20);
        host.tick();
        wait_pin(0, 1'b0, 3);
        rd_chk(ADDR_FLAGS, 8'h80);
        host.wr(ADDR_FLAGS, 8'h7f);
        wait_pin(0, 1'b1, 3);
        repeat (4) @(posedge clock);
        finish_test();
    end
endmodule // tb_wdtc_timer

`default_nettype wire
